/* File: common/swf_pkg.sv */
// package: register map, field layout, reset values and timing for the sleep/wake/fault bank
package swf_pkg;
  localparam logic [7:0] REG_RAIL3_LINREG_SLEEP_WAKE_CFG = 8'h06;
  localparam logic [7:0] REG_EXT_OUTPUTS_SLEEP_WAKE_CFG = 8'h07;
  localparam logic [7:0] REG_PRODUCT_IDENTITY = 8'h0A;
  localparam logic [7:0] REG_MAKER_IDENTITY = 8'h0B;
  localparam logic [7:0] REG_SILICON_REVISION = 8'h0C;
  localparam logic [7:0] REG_FAULT_STATUS = 8'h0D;
  localparam logic [7:0] RST_RAIL3_LINREG_CFG = 8'hE1;
  localparam logic [7:0] RST_EXT_OUTPUTS_CFG = 8'h8A;
  // arbitrary neutral identity values
  localparam logic [7:0] PRODUCT_CODE_DEFAULT = 8'h5A;
  localparam logic [7:0] MAKER_CODE_DEFAULT = 8'hA5;
  localparam logic [7:0] SILICON_REVISION_VALUE = 8'h00;
  localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;
  // field positions within each config register
  localparam int SLOT_HI_MSB = 7;
  localparam int SLOT_HI_LSB = 5;
  localparam int KEEP_HI_BIT = 4;
  localparam int SLOT_LO_MSB = 3;
  localparam int SLOT_LO_LSB = 1;
  localparam int KEEP_LO_BIT = 0;
  // fault status bit positions
  localparam int FS_RAIL1_UV = 7;
  localparam int FS_RAIL2_UV = 6;
  localparam int FS_RAIL3_UV = 5;
  localparam int FS_LINREG_UV = 4;
  localparam int FS_OVERTEMP = 3;
  localparam int FS_INPUT_OV = 2;
  localparam int FS_GATE_READY = 1;
  localparam int FS_OUTPUT_POR = 0;
  // wake timing
  localparam int CLK_FREQ_HZ = 20_000_000;
  localparam int WAKE_BASE_US = 150;
  localparam int WAKE_STEP_US = 512;
  localparam int WAKE_BASE_CYCLES = (WAKE_BASE_US * (CLK_FREQ_HZ / 1_000_000));
  localparam int WAKE_STEP_CYCLES = (WAKE_STEP_US * (CLK_FREQ_HZ / 1_000_000));
  localparam int NUM_OUTPUTS = 4;
  localparam int SLOT_W = 3;
  // wide enough for the slowest slot delay
  localparam int TIMER_W = $clog2(WAKE_BASE_CYCLES + ((1 << SLOT_W) - 1) * WAKE_STEP_CYCLES + 1);
  typedef enum logic [1:0] {
    SWF_AWAKE,
    SWF_ASLEEP,
    SWF_WAKING,
    SWF_LATCHED
  } swf_state_t;
endpackage : swf_pkg

/* File: tb/swf_host_model.sv */
// host model: single-byte register writes and reads through the strobe port
`timescale 1ns/1ps
module swf_host_model (
  // clock
  input wire logic i_sys_clk,
  // register access
  output logic o_reg_wr,
  output logic o_reg_rd,
  output logic [7:0] o_reg_addr,
  output logic [7:0] o_reg_wdata,
  input wire logic [7:0] i_reg_rdata
);
  initial begin
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
    o_reg_addr = 8'hFF;
    o_reg_wdata = 8'hFF;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_sys_clk);
    o_reg_wr <= 1'b1;
    o_reg_addr <= a;
    o_reg_wdata <= v;
    @(posedge i_sys_clk);
    o_reg_wr <= 1'b0;
    // released lines show the inverse so stale values never match
    o_reg_addr <= ~a;
    o_reg_wdata <= ~v;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge i_sys_clk);
    o_reg_rd <= 1'b1;
    o_reg_addr <= a;
    @(posedge i_sys_clk);
    o_reg_rd <= 1'b0;
    o_reg_addr <= ~a;
    @(posedge i_sys_clk);
    #1 v = i_reg_rdata;
  endtask : rd
endmodule : swf_host_model

/* File: tb/swf_regs_properties.sv */
// checker: register reads, undervoltage latch and sleep relations at the bank ports
`timescale 1ns/1ps
module swf_regs_properties
  import swf_pkg::*;
#(
  parameter logic [7:0] PRODUCT_CODE = PRODUCT_CODE_DEFAULT,
  parameter logic [7:0] MAKER_CODE = MAKER_CODE_DEFAULT
) (
  // clock, reset and register access
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] o_reg_rdata,
  // power state
  input wire logic i_sleep_req,
  input wire logic o_rail3_en,
  input wire logic o_linreg_en,
  input wire logic o_ext_out1,
  input wire logic o_ext_out2,
  input wire logic o_rail3_sleep_mode,
  input wire logic o_linreg_sleep_mode,
  input wire logic o_uv_latched
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  prod_code_a: assert property (i_reg_rd && i_reg_addr == REG_PRODUCT_IDENTITY |=> o_reg_rdata == PRODUCT_CODE)
    else $error("product code read wrong");
  maker_code_a: assert property (i_reg_rd && i_reg_addr == REG_MAKER_IDENTITY |=> o_reg_rdata == MAKER_CODE)
    else $error("maker code read wrong");
  rev_zero_a: assert property (i_reg_rd && i_reg_addr == REG_SILICON_REVISION |=> o_reg_rdata == 8'h00)
    else $error("revision not zero");
  uv_all_off_a: assert property (o_uv_latched |=> !(o_rail3_en || o_linreg_en || o_ext_out1 || o_ext_out2))
    else $error("output on while undervoltage latched");
  uv_sticky_a: assert property (o_uv_latched |=> o_uv_latched)
    else $error("undervoltage latch dropped");
  uv_status_a: assert property (o_uv_latched ##1 (i_reg_rd && i_reg_addr == REG_FAULT_STATUS)
    |=> o_reg_rdata[7:4] != 4'h0) else $error("no undervoltage flag while latched");
  rail3_keep_a: assert property (o_rail3_sleep_mode && !o_uv_latched |-> o_rail3_en)
    else $error("kept rail3 off in sleep");
  linreg_keep_a: assert property (o_linreg_sleep_mode && !o_uv_latched |-> o_linreg_en)
    else $error("kept linreg off in sleep");
  wake_delay_a: assert property ($rose(o_ext_out1) |-> $past(i_sleep_req, 4) == 1'b0)
    else $error("ext_out1 rose too soon after wake");
endmodule : swf_regs_properties

bind swf_regs swf_regs_properties #(.PRODUCT_CODE(PRODUCT_CODE), .MAKER_CODE(MAKER_CODE)) i_swf_regs_properties (
  .i_sys_clk, .i_rst_n, .i_reg_rd, .i_reg_addr, .o_reg_rdata, .i_sleep_req, .o_rail3_en, .o_linreg_en,
  .o_ext_out1, .o_ext_out2, .o_rail3_sleep_mode, .o_linreg_sleep_mode, .o_uv_latched);

/* File: tb/test_swf_regs.sv */
// testbench: register map, fault status, sleep and wake sequencing of the bank
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; $display("BAD %s exp %h got %h", nm, e, g); end end
module test_swf_regs;
  import swf_pkg::*;
  localparam int BASE = 3;
  localparam int STEP = 2;
  // arbitrary identity values
  localparam logic [7:0] PCODE = 8'h3C;
  localparam logic [7:0] MCODE = 8'hC3;
  logic i_sys_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic reg_wr, reg_rd, rail3_en, linreg_en, ext1, ext2, r3_sm, lr_sm, uv_l;
  logic [7:0] reg_addr, reg_wdata, rdata, d;
  logic sleep_req = 1'b0;
  // rail1, rail2, rail3, linreg undervolt, overtemp, input overvolt
  logic [5:0] fault = 6'h00;
  logic gate_ready = 1'b1;
  logic por_ok = 1'b1;
  logic [3:0] outs;
  int error_cnt = 0;
  int samples_checked = 0;
  assign outs = {ext2, ext1, linreg_en, rail3_en};
  swf_host_model i_swf_host_model (.i_sys_clk(i_sys_clk), .o_reg_wr(reg_wr), .o_reg_rd(reg_rd),
    .o_reg_addr(reg_addr), .o_reg_wdata(reg_wdata), .i_reg_rdata(rdata));
  swf_regs #(.PRODUCT_CODE(PCODE), .MAKER_CODE(MCODE), .BASE_CYCLES(BASE), .STEP_CYCLES(STEP)) i_swf_regs (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .i_reg_addr(reg_addr),
    .i_reg_wdata(reg_wdata), .o_reg_rdata(rdata), .i_sleep_req(sleep_req), .i_rail1_uv(fault[5]),
    .i_rail2_uv(fault[4]), .i_rail3_uv(fault[3]), .i_linreg_uv(fault[2]), .i_overtemp(fault[1]),
    .i_input_ov(fault[0]), .i_gate_ready(gate_ready), .i_output_por_ok(por_ok), .o_rail3_en(rail3_en),
    .o_linreg_en(linreg_en), .o_ext_out1(ext1), .o_ext_out2(ext2), .o_rail3_sleep_mode(r3_sm),
    .o_linreg_sleep_mode(lr_sm), .o_uv_latched(uv_l));
  always #25 i_sys_clk = ~i_sys_clk;
  task automatic results();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    i_swf_host_model.rd(a, d);
    `CHK(nm, e, d)
  endtask : chk_rd
  task automatic do_reset();
    @(posedge i_sys_clk) i_rst_n <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    repeat (6) @(posedge i_sys_clk);
    #1;
  endtask : do_reset
  task automatic t_reset_values();
    repeat (6) @(posedge i_sys_clk);
    chk_rd(REG_RAIL3_LINREG_SLEEP_WAKE_CFG, 8'hE1, "cfg06");
    chk_rd(REG_EXT_OUTPUTS_SLEEP_WAKE_CFG, 8'h8A, "cfg07");
    chk_rd(REG_FAULT_STATUS, 8'h03, "status");
  endtask : t_reset_values
  task automatic t_read_only();
    logic [7:0] ro_exp [4] = '{PCODE, MCODE, 8'h00, 8'h03};
    for (int k = 0; k < 4; k++) begin
      i_swf_host_model.wr(8'h0A + k[7:0], 8'hFC);
      chk_rd(8'h0A + k[7:0], ro_exp[k], "read only");
    end
    i_swf_host_model.wr(8'h20, 8'hFF);
    chk_rd(8'h20, UNMAPPED_READ_VALUE, "unmapped");
  endtask : t_read_only
  task automatic t_status();
    for (int b = 0; b < 2; b++) begin
      @(posedge i_sys_clk) fault[1-b] <= 1'b1;
      repeat (6) @(posedge i_sys_clk);
      chk_rd(REG_FAULT_STATUS, 8'h03 | (8'h08 >> b), "live fault");
      @(posedge i_sys_clk) fault[1-b] <= 1'b0;
    end
    @(posedge i_sys_clk) gate_ready <= 1'b0;
    repeat (6) @(posedge i_sys_clk);
    chk_rd(REG_FAULT_STATUS, 8'h01, "gate monitor");
    @(posedge i_sys_clk) gate_ready <= 1'b1;
    @(posedge i_sys_clk) por_ok <= 1'b0;
    repeat (6) @(posedge i_sys_clk);
    chk_rd(REG_FAULT_STATUS, 8'h02, "por monitor");
    @(posedge i_sys_clk) por_ok <= 1'b1;
    repeat (6) @(posedge i_sys_clk);
  endtask : t_status
  task automatic t_sleep_wake(input logic [7:0] c6, input logic [7:0] c7);
    logic [7:0] cfg;
    logic [3:0] keep;
    int slot [4];
    int rise [4];
    int ref_t;
    i_swf_host_model.wr(REG_RAIL3_LINREG_SLEEP_WAKE_CFG, c6);
    i_swf_host_model.wr(REG_EXT_OUTPUTS_SLEEP_WAKE_CFG, c7);
    chk_rd(REG_RAIL3_LINREG_SLEEP_WAKE_CFG, c6, "cfg06 rw");
    chk_rd(REG_EXT_OUTPUTS_SLEEP_WAKE_CFG, c7, "cfg07 rw");
    for (int i = 0; i < 4; i++) begin
      cfg = (i < 2) ? c6 : c7;
      keep[i] = (i % 2) ? cfg[0] : cfg[4];
      slot[i] = (i % 2) ? int'(cfg[3:1]) : int'(cfg[7:5]);
      rise[i] = -1;
    end
    @(posedge i_sys_clk) sleep_req <= 1'b1;
    repeat (10) @(posedge i_sys_clk);
    #1;
    `CHK("asleep", keep, outs)
    `CHK("sleep mode", keep[1:0], {lr_sm, r3_sm})
    @(posedge i_sys_clk) sleep_req <= 1'b0;
    for (int c = 0; c < 100; c++) begin
      @(posedge i_sys_clk) #1;
      for (int i = 0; i < 4; i++) if (outs[i] === 1'b1 && rise[i] < 0) rise[i] = c;
    end
    ref_t = -1;
    for (int i = 0; i < 4; i++) if (!keep[i]) begin
      if (ref_t < 0) ref_t = rise[i] - slot[i] * STEP;
      `CHK("wake slot", ref_t, rise[i] - slot[i] * STEP)
    end
    `CHK("base delay", 1'b1, ref_t >= BASE)
    `CHK("awake", 4'hF, outs)
  endtask : t_sleep_wake
  task automatic t_undervolt();
    for (int j = 0; j < 4; j++) begin
      @(posedge i_sys_clk) fault[5-j] <= 1'b1;
      repeat (8) @(posedge i_sys_clk);
      fault[5-j] <= 1'b0;
      repeat (4) @(posedge i_sys_clk);
      #1;
      `CHK("outputs off", 5'h10, {uv_l, outs})
      chk_rd(REG_FAULT_STATUS, 8'h03 | (8'h80 >> j), "uv flag");
      do_reset();
      `CHK("uv cleared", 5'h0F, {uv_l, outs})
      chk_rd(REG_FAULT_STATUS, 8'h03, "status cleared");
    end
  endtask : t_undervolt
  initial begin
    #2000000;
    error_cnt++;
    results();
  end
  initial begin
    repeat (2) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    t_reset_values();
    t_read_only();
    t_status();
    t_sleep_wake(8'h30, 8'h47);
    t_sleep_wake(8'hE1, 8'h8A);
    t_undervolt();
    results();
  end
endmodule : test_swf_regs

/* File: verilog/swf_regs.sv */
// sleep/wake configuration and fault status register bank with output sequencing
// Operation
// - reg 0x06: rail3 and linreg wake slots
// - rail3 off in sleep unless kept
// - linreg off in sleep unless kept
// - reg 0x07: external output wake slots
// - ext_out1 dropped in sleep unless kept
// - ext_out2 dropped in sleep unless kept
// - 0x0A returns fixed product code
// - 0x0B returns fixed maker code
// - 0x0C revision reads all zero
// - status bits 7..4 rail undervoltage
// - status bit 3 overtemperature
// - status bit 2 input overvoltage
// - bits 1,0 internal monitors, reset one
// - fault status read-only, writes ignored
// - wake delay 150us plus N*512us
// - undervolt latches, all off until POR
`timescale 1ns/1ps
module swf_regs
  import swf_pkg::*;
#(
  parameter logic [7:0] PRODUCT_CODE = PRODUCT_CODE_DEFAULT,
  parameter logic [7:0] MAKER_CODE = MAKER_CODE_DEFAULT,
  parameter int BASE_CYCLES = WAKE_BASE_CYCLES,
  parameter int STEP_CYCLES = WAKE_STEP_CYCLES
) (
  // clock and input-supply power-on reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // register access from the serial-bus front end
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  // power-state requests, level from pins or logic
  input wire logic i_sleep_req,
  // analogue monitor levels
  input wire logic i_rail1_uv,
  input wire logic i_rail2_uv,
  input wire logic i_rail3_uv,
  input wire logic i_linreg_uv,
  input wire logic i_overtemp,
  input wire logic i_input_ov,
  input wire logic i_gate_ready,
  input wire logic i_output_por_ok,
  // output enables: rail3, linreg, ext_out1, ext_out2; then sleep-mode flags and undervoltage latch
  output logic o_rail3_en,
  output logic o_linreg_en,
  output logic o_ext_out1,
  output logic o_ext_out2,
  output logic o_rail3_sleep_mode,
  output logic o_linreg_sleep_mode,
  output logic o_uv_latched
);
  localparam int MON_W = 8;
  // internal monitors idle high, so status reads one straight out of reset
  localparam logic [MON_W-1:0] MON_RST = MON_W'((1 << FS_GATE_READY) | (1 << FS_OUTPUT_POR));

  logic [7:0] rail3_linreg_sleep_wake_cfg_q;
  logic [7:0] ext_outputs_sleep_wake_cfg_q;
  logic [MON_W-1:0] mon_s1_q;
  logic [MON_W-1:0] mon_s2_q;
  logic [MON_W-1:0] mon_s3_q;
  logic [MON_W-1:0] mon_q;
  logic [MON_W-1:0] mon_raw;
  logic sleep_s1_q;
  logic sleep_s2_q;
  logic sleep_s3_q;
  logic sleep_q;
  logic sleep_prev_q;
  logic sleep_entry;
  logic wake_entry;
  logic [7:0] fault_status_q;
  logic uv_any;
  swf_state_t state_q;
  logic [NUM_OUTPUTS-1:0] out_en_q;
  logic [NUM_OUTPUTS-1:0] keep_q;
  logic [NUM_OUTPUTS-1:0] keep_cfg;
  logic [NUM_OUTPUTS-1:0] timer_done;
  logic [NUM_OUTPUTS-1:0] timer_start;
  logic [SLOT_W-1:0] slot_cfg [NUM_OUTPUTS];

  function automatic logic [SLOT_W-1:0] slot_hi(input logic [7:0] cfg);
    slot_hi = cfg[SLOT_HI_MSB:SLOT_HI_LSB];
  endfunction : slot_hi

  function automatic logic [SLOT_W-1:0] slot_lo(input logic [7:0] cfg);
    slot_lo = cfg[SLOT_LO_MSB:SLOT_LO_LSB];
  endfunction : slot_lo

  assign slot_cfg[0] = slot_hi(rail3_linreg_sleep_wake_cfg_q);
  assign slot_cfg[1] = slot_lo(rail3_linreg_sleep_wake_cfg_q);
  assign slot_cfg[2] = slot_hi(ext_outputs_sleep_wake_cfg_q);
  assign slot_cfg[3] = slot_lo(ext_outputs_sleep_wake_cfg_q);

  assign keep_cfg = {ext_outputs_sleep_wake_cfg_q[KEEP_LO_BIT], ext_outputs_sleep_wake_cfg_q[KEEP_HI_BIT],
                     rail3_linreg_sleep_wake_cfg_q[KEEP_LO_BIT], rail3_linreg_sleep_wake_cfg_q[KEEP_HI_BIT]};

  // config registers
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      rail3_linreg_sleep_wake_cfg_q <= RST_RAIL3_LINREG_CFG;
      ext_outputs_sleep_wake_cfg_q <= RST_EXT_OUTPUTS_CFG;
    end else if (i_reg_wr) begin
      case (i_reg_addr)
        REG_RAIL3_LINREG_SLEEP_WAKE_CFG: begin
          rail3_linreg_sleep_wake_cfg_q <= i_reg_wdata;
        end
        REG_EXT_OUTPUTS_SLEEP_WAKE_CFG: begin
          ext_outputs_sleep_wake_cfg_q <= i_reg_wdata;
        end
        default: begin
        end
      endcase
    end
  end

  assign mon_raw = {i_rail1_uv, i_rail2_uv, i_rail3_uv, i_linreg_uv,
                    i_overtemp, i_input_ov, i_gate_ready, i_output_por_ok};

  // pin synchronisers, change accepted when stages two and three agree
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      mon_s1_q <= MON_RST;
      mon_s2_q <= MON_RST;
      mon_s3_q <= MON_RST;
      mon_q <= MON_RST;
      sleep_s1_q <= 1'b0;
      sleep_s2_q <= 1'b0;
      sleep_s3_q <= 1'b0;
      sleep_q <= 1'b0;
    end else begin
      mon_s1_q <= mon_raw;
      mon_s2_q <= mon_s1_q;
      mon_s3_q <= mon_s2_q;
      for (int i = 0; i < MON_W; i++) begin
        if (mon_s2_q[i] == mon_s3_q[i]) begin
          mon_q[i] <= mon_s3_q[i];
        end
      end
      sleep_s1_q <= i_sleep_req;
      sleep_s2_q <= sleep_s1_q;
      sleep_s3_q <= sleep_s2_q;
      if (sleep_s2_q == sleep_s3_q) begin
        sleep_q <= sleep_s3_q;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      sleep_prev_q <= 1'b0;
    end else begin
      sleep_prev_q <= sleep_q;
    end
  end

  assign sleep_entry = sleep_q && !sleep_prev_q;
  assign wake_entry = !sleep_q && sleep_prev_q;

  // fault status: latched events, live monitors
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      fault_status_q <= '0;
      fault_status_q[FS_GATE_READY] <= 1'b1;
      fault_status_q[FS_OUTPUT_POR] <= 1'b1;
    end else begin
      fault_status_q[FS_RAIL1_UV] <= fault_status_q[FS_RAIL1_UV] | mon_q[FS_RAIL1_UV];
      fault_status_q[FS_RAIL2_UV] <= fault_status_q[FS_RAIL2_UV] | mon_q[FS_RAIL2_UV];
      fault_status_q[FS_RAIL3_UV] <= fault_status_q[FS_RAIL3_UV] | mon_q[FS_RAIL3_UV];
      fault_status_q[FS_LINREG_UV] <= fault_status_q[FS_LINREG_UV] | mon_q[FS_LINREG_UV];
      fault_status_q[FS_OVERTEMP] <= mon_q[FS_OVERTEMP];
      fault_status_q[FS_INPUT_OV] <= mon_q[FS_INPUT_OV];
      fault_status_q[FS_GATE_READY] <= mon_q[FS_GATE_READY];
      fault_status_q[FS_OUTPUT_POR] <= mon_q[FS_OUTPUT_POR];
    end
  end

  assign uv_any = |mon_q[FS_RAIL1_UV:FS_LINREG_UV];

  // sequencing state
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      state_q <= SWF_AWAKE;
      keep_q <= '0;
    end else begin
      case (state_q)
        SWF_AWAKE: begin
          if (sleep_entry) begin
            keep_q <= keep_cfg;
            state_q <= SWF_ASLEEP;
          end
        end
        SWF_ASLEEP: begin
          if (wake_entry) begin
            state_q <= SWF_WAKING;
          end
        end
        SWF_WAKING: begin
          if (sleep_entry) begin
            keep_q <= keep_cfg;
            state_q <= SWF_ASLEEP;
          end else if (&out_en_q) begin
            state_q <= SWF_AWAKE;
          end
        end
        SWF_LATCHED: begin
          state_q <= SWF_LATCHED;
        end
        default: begin
          state_q <= SWF_AWAKE;
        end
      endcase
      if (uv_any) begin
        state_q <= SWF_LATCHED;
      end
    end
  end

  assign timer_start = (state_q == SWF_ASLEEP && wake_entry) ? ~out_en_q : '0;

  genvar g;
  generate
    for (g = 0; g < NUM_OUTPUTS; g++) begin : g_out
      swf_wake_timer #(
        .BASE_CYCLES(BASE_CYCLES),
        .STEP_CYCLES(STEP_CYCLES)
      ) u_timer (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_start(timer_start[g]),
        .i_abort(sleep_entry || uv_any || state_q == SWF_LATCHED),
        .i_slot(slot_cfg[g]),
        .o_done(timer_done[g])
      );

      always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
          out_en_q[g] <= 1'b1;
        end else if (uv_any || state_q == SWF_LATCHED) begin
          out_en_q[g] <= 1'b0;
        end else if (sleep_entry && (state_q == SWF_AWAKE || state_q == SWF_WAKING)) begin
          out_en_q[g] <= keep_cfg[g] & out_en_q[g];
        end else if (timer_done[g]) begin
          out_en_q[g] <= 1'b1;
        end
      end
    end
  endgenerate

  assign o_rail3_en = out_en_q[0];
  assign o_linreg_en = out_en_q[1];
  assign o_ext_out1 = out_en_q[2];
  assign o_ext_out2 = out_en_q[3];

  // kept rails run in sleep operation
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_rail3_sleep_mode <= 1'b0;
      o_linreg_sleep_mode <= 1'b0;
      o_uv_latched <= 1'b0;
    end else begin
      o_rail3_sleep_mode <= (state_q == SWF_ASLEEP) && keep_q[0];
      o_linreg_sleep_mode <= (state_q == SWF_ASLEEP) && keep_q[1];
      o_uv_latched <= (state_q == SWF_LATCHED) || uv_any;
    end
  end

  // read mux, registered
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_reg_rdata <= UNMAPPED_READ_VALUE;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        REG_RAIL3_LINREG_SLEEP_WAKE_CFG: o_reg_rdata <= rail3_linreg_sleep_wake_cfg_q;
        REG_EXT_OUTPUTS_SLEEP_WAKE_CFG: o_reg_rdata <= ext_outputs_sleep_wake_cfg_q;
        REG_PRODUCT_IDENTITY: o_reg_rdata <= PRODUCT_CODE;
        REG_MAKER_IDENTITY: o_reg_rdata <= MAKER_CODE;
        REG_SILICON_REVISION: o_reg_rdata <= SILICON_REVISION_VALUE;
        REG_FAULT_STATUS: o_reg_rdata <= fault_status_q;
        default: o_reg_rdata <= UNMAPPED_READ_VALUE;
      endcase
    end
  end
endmodule : swf_regs

/* File: verilog/swf_wake_timer.sv */
// per-output wake delay: raises done after base plus slot times step cycles
`timescale 1ns/1ps
module swf_wake_timer
  import swf_pkg::*;
#(
  parameter int BASE_CYCLES = WAKE_BASE_CYCLES,
  parameter int STEP_CYCLES = WAKE_STEP_CYCLES
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // control
  input wire logic i_start,
  input wire logic i_abort,
  input wire logic [SLOT_W-1:0] i_slot,
  // status
  output logic o_done
);
  logic [TIMER_W-1:0] count_q;
  logic [TIMER_W-1:0] target_q;
  logic run_q;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n || i_abort) begin
      run_q <= 1'b0;
      count_q <= '0;
      target_q <= '0;
      o_done <= 1'b0;
    end else if (i_start) begin
      run_q <= 1'b1;
      count_q <= '0;
      target_q <= TIMER_W'(BASE_CYCLES + int'(i_slot) * STEP_CYCLES - 1);
      o_done <= 1'b0;
    end else if (run_q) begin
      if (count_q == target_q) begin
        run_q <= 1'b0;
        o_done <= 1'b1;
      end else begin
        count_q <= count_q + TIMER_W'(1);
      end
    end else begin
      o_done <= 1'b0;
    end
  end
endmodule : swf_wake_timer
